// ===== core/bss_top.sv
// boot strap select: latches boot straps five clock edges after reset release and derives boot decisions
// Summary of operation
// RL1 - sample strap pins after reset ends and derive boot modes from them
// RL2 - processor core owns the signal processor reset release in normal mode
// RL3 - signal processor has no loader; code comes from core or outside
// RL4 - core offers eight boot modes including host, nand, serial, pci, pci ai, i2c, spi, async
// RL5 - core boot mode comes from the four-bit strap field
// RL6 - async boot takes address bus width from chip select 2 width straps
// RL7 - direct async boot moves no code and branches to fixed nor address
// RL8 - effective self-boot strap of one lets signal processor boot itself
// RL9 - in self-boot signal processor reset releases automatically
// RL10 - self-boot start address is fixed async memory location
// RL11 - self-boot starts with level one program cache enabled
// RL12 - mode field 001x forces host port or pci pin enable to one
// RL13 - forced pin function takes async interface from signal processor
// RL14 - mode field 001x forces self-boot to zero internally
// RL15 - config latch keeps true self-boot pin level
// RL16 - latched straps and decisions stay constant until next reset
`timescale 1ns/1ps
`include "bss_params.svh"
module bss_top
  import bss_pkg::*;
(
  input  wire logic                  MCLK_IN,             // 40 MHz system clock
  input  wire logic                  RST_IN,              // async power-on reset, high
  input  wire logic [3:0]            BOOT_MODE_STRAPS_IN, // boot mode strap pins
  input  wire logic [1:0]            CS2_BUS_WIDTH_IN,    // chip select 2 width straps
  input  wire logic                  DSP_SELF_BOOT_IN,    // self-boot strap pin
  input  wire logic                  CORE_DSP_RELEASE_IN, // core request to free dsp
  output logic                       CFG_VALID_OUT,       // straps latched
  output bss_cfg_t                   BOOT_CONFIG_OUT,     // raw latched straps
  output logic [3:0]                 CORE_BOOT_MODE_OUT,  // core boot mode
  output logic                       CORE_MODE_VALID_OUT, // mode code is one of eight
  output logic                       CORE_XFER_CODE_OUT,  // loader transfers code
  output logic [31:0]                CORE_BRANCH_ADDR_OUT,// direct branch address
  output logic [1:0]                 ASYNC_ADDR_WIDTH_OUT,// async bus width for boot
  output logic                       HOST_PORT_PIN_EN_OUT,// host port pin enable
  output logic                       PCI_PIN_EN_OUT,      // pci pin function enable
  output logic                       DSP_ASYNC_ALLOWED_OUT,// dsp may use async iface
  output logic                       DSP_SELF_BOOT_OUT,   // effective self-boot
  output logic                       DSP_RESET_N_OUT,     // dsp reset, active low
  output logic                       DSP_L1P_EN_OUT,      // dsp program cache enable
  output logic [31:0]                DSP_BOOT_ADDR_OUT    // dsp start address
);

  typedef enum logic [1:0] {
    BSS_ST_SAMPLE  = 2'b00,
    BSS_ST_LATCH   = 2'b01,
    BSS_ST_HOLD    = 2'b10
  } bss_state_t;

  logic [`BSS_MODE_W-1:0] mode_sync;
  logic [`BSS_BW_W-1:0]   bw_sync;
  logic                   dsp_sync;
  logic                   rel_sync;

  // straps come straight from board pins, so they are synchronised first
  bss_sync #(.W(8)) u_sync (
    .clk_in (MCLK_IN),
    .rst_in (RST_IN),
    .d_in   ({BOOT_MODE_STRAPS_IN, CS2_BUS_WIDTH_IN, DSP_SELF_BOOT_IN, CORE_DSP_RELEASE_IN}),
    .q_out  ({mode_sync, bw_sync, dsp_sync, rel_sync})
  );

  bss_state_t   state_ff;
  bss_state_t   nxt_state;
  logic [3:0]   dly_ff;
  logic [3:0]   nxt_dly;
  bss_cfg_t     cfg_ff;
  bss_cfg_t     nxt_cfg;
  logic         hostpci_ff;
  logic         nxt_hostpci;
  logic         self_ff;
  logic         nxt_self;
  logic         rel_ff;
  logic         nxt_rel;
  bss_dsp_ctl_t dsp_ff;
  bss_dsp_ctl_t nxt_dsp;

  // wait for synchroniser to fill before sampling; flops hold reset value till then
  always_comb begin
    nxt_state   = state_ff;
    nxt_dly     = dly_ff;
    nxt_cfg     = cfg_ff;
    nxt_hostpci = hostpci_ff;
    nxt_self    = self_ff;
    unique case (state_ff)
      BSS_ST_SAMPLE: begin
        if (dly_ff == `BSS_RELEASE_DLY) begin
          nxt_state = BSS_ST_LATCH;
        end else begin
          nxt_dly = dly_ff + 4'h1;
        end
      end
      BSS_ST_LATCH: begin
        nxt_cfg.boot_mode_straps       = mode_sync;            // RL1 RL5
        nxt_cfg.chip_select2_bus_width = bw_sync;              // RL6
        nxt_cfg.dsp_self_boot_strap    = dsp_sync;             // RL15
        nxt_cfg.spare                  = 1'b0;
        nxt_hostpci = (mode_sync & `BSS_HOSTPCI_MASK) == `BSS_HOSTPCI_VAL; // RL12
        nxt_self    = dsp_sync & ~nxt_hostpci;                 // RL14 RL8
        nxt_state   = BSS_ST_HOLD;
      end
      BSS_ST_HOLD: begin
        nxt_state = BSS_ST_HOLD;                               // RL16
      end
      default: begin
        nxt_state = BSS_ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_ff   <= BSS_ST_SAMPLE;
      dly_ff     <= 4'h0;
      cfg_ff     <= '0;
      hostpci_ff <= 1'b0;
      self_ff    <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      dly_ff     <= nxt_dly;
      cfg_ff     <= nxt_cfg;
      hostpci_ff <= nxt_hostpci;
      self_ff    <= nxt_self;
    end
  end

  wire logic cfg_valid = (state_ff == BSS_ST_HOLD);

  // dsp reset control: once released it stays released until the next reset
  always_comb begin
    nxt_rel = rel_ff;
    nxt_dsp = dsp_ff;
    if (cfg_valid) begin
      if (self_ff) begin
        nxt_rel = 1'b1;                                        // RL9 RL8
        nxt_dsp.dsp_l1p_enable = 1'b1;                         // RL11
        nxt_dsp.dsp_boot_addr  = `BSS_DSP_BOOT_ADDR;           // RL10
      end else if (rel_sync) begin
        // normal mode: the core loads dsp code, then frees it
        nxt_rel = 1'b1;                                        // RL2 RL3
      end
      nxt_dsp.dsp_reset_release = nxt_rel;
    end
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rel_ff <= 1'b0;
      dsp_ff <= '0;
    end else begin
      rel_ff <= nxt_rel;
      dsp_ff <= nxt_dsp;
    end
  end

  // decoded core boot outputs, registered
  logic [3:0]  mode_q;
  logic        mode_ok_q;
  logic        xfer_q;
  logic [31:0] branch_q;
  logic [1:0]  bw_q;
  logic [3:0]  nxt_mode;
  logic        nxt_mode_ok;
  logic        nxt_xfer;
  logic [31:0] nxt_branch;
  logic [1:0]  nxt_bw;

  always_comb begin
    nxt_mode    = cfg_ff.boot_mode_straps;                     // RL5
    nxt_mode_ok = 1'b0;
    nxt_xfer    = 1'b0;
    nxt_branch  = 32'h0;
    nxt_bw      = 2'h0;
    if (cfg_valid) begin
      unique case (cfg_ff.boot_mode_straps)
        BSS_BOOT_NAND, BSS_BOOT_SERIAL0, BSS_BOOT_HOST, BSS_BOOT_PCI,
        BSS_BOOT_PCI_AI, BSS_BOOT_I2C, BSS_BOOT_SPI: begin
          nxt_mode_ok = 1'b1;                                  // RL4
          nxt_xfer    = 1'b1;
        end
        BSS_BOOT_ASYNC: begin
          nxt_mode_ok = 1'b1;                                  // RL4
          nxt_xfer    = 1'b0;                                  // RL7
          nxt_branch  = `BSS_NOR_ADDR;                         // RL7
          nxt_bw      = cfg_ff.chip_select2_bus_width;         // RL6
        end
        default: begin
          nxt_mode_ok = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      mode_q    <= 4'h0;
      mode_ok_q <= 1'b0;
      xfer_q    <= 1'b0;
      branch_q  <= 32'h0;
      bw_q      <= 2'h0;
    end else begin
      mode_q    <= nxt_mode;
      mode_ok_q <= nxt_mode_ok;
      xfer_q    <= nxt_xfer;
      branch_q  <= nxt_branch;
      bw_q      <= nxt_bw;
    end
  end

  assign CFG_VALID_OUT         = cfg_valid;
  assign BOOT_CONFIG_OUT       = cfg_ff;                       // RL15
  assign CORE_BOOT_MODE_OUT    = mode_q;
  assign CORE_MODE_VALID_OUT   = mode_ok_q;
  assign CORE_XFER_CODE_OUT    = xfer_q;
  assign CORE_BRANCH_ADDR_OUT  = branch_q;
  assign ASYNC_ADDR_WIDTH_OUT  = bw_q;
  // odd code of the 001x pair selects pci, even selects host port
  assign HOST_PORT_PIN_EN_OUT  = hostpci_ff & ~cfg_ff.boot_mode_straps[0]; // RL12
  assign PCI_PIN_EN_OUT        = hostpci_ff & cfg_ff.boot_mode_straps[0];  // RL12
  assign DSP_ASYNC_ALLOWED_OUT = cfg_valid & ~hostpci_ff;      // RL13
  assign DSP_SELF_BOOT_OUT     = self_ff;
  assign DSP_RESET_N_OUT       = dsp_ff.dsp_reset_release;
  assign DSP_L1P_EN_OUT        = dsp_ff.dsp_l1p_enable;
  assign DSP_BOOT_ADDR_OUT     = dsp_ff.dsp_boot_addr;

endmodule : bss_top

// ===== core/bss_params.svh
// boot strap select constants
`ifndef BSS_PARAMS_SVH
`define BSS_PARAMS_SVH
`define BSS_MODE_W          4
`define BSS_BW_W            2
`define BSS_HOSTPCI_MASK    4'he
`define BSS_HOSTPCI_VAL     4'h2
`define BSS_HOST_CODE       4'h2
`define BSS_PCI_CODE        4'h3
`define BSS_NOR_ADDR        32'h42000000
`define BSS_DSP_BOOT_ADDR   32'h42200000
`define BSS_CFG_W           8
`define BSS_RELEASE_DLY     4'h3
`endif

// ===== core/bss_pkg.sv
// boot strap select types
`include "bss_params.svh"
package bss_pkg;
  typedef enum logic [3:0] {
    BSS_BOOT_NAND    = 4'h0,
    BSS_BOOT_SERIAL0 = 4'h1,
    BSS_BOOT_HOST    = 4'h2,
    BSS_BOOT_PCI     = 4'h3,
    BSS_BOOT_PCI_AI  = 4'h4,
    BSS_BOOT_I2C     = 4'h5,
    BSS_BOOT_SPI     = 4'h6,
    BSS_BOOT_ASYNC   = 4'h7,
    BSS_BOOT_RSVD    = 4'hf
  } bss_boot_t;

  typedef struct packed {
    logic [3:0] boot_mode_straps;
    logic [1:0] chip_select2_bus_width;
    logic       dsp_self_boot_strap;
    logic       spare;
  } bss_cfg_t;

  typedef struct packed {
    logic        dsp_reset_release;
    logic        dsp_l1p_enable;
    logic [31:0] dsp_boot_addr;
  } bss_dsp_ctl_t;
endpackage : bss_pkg

// ===== core/bss_sync.sv
// two-flop synchroniser for strap pins
`timescale 1ns/1ps
module bss_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,    // system clock
  input  wire logic         rst_in,    // async reset, active high
  input  wire logic [W-1:0] d_in,      // asynchronous pins
  output logic      [W-1:0] q_out      // synchronised level
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= d_in;
      sync_ff <= meta_ff;
    end
  end

  assign q_out = sync_ff;
endmodule : bss_sync

// ===== verification/bss_top_chk.sv
// port assertions for the boot strap select block
`timescale 1ns/1ps
`include "bss_params.svh"
module bss_top_chk
  import bss_pkg::*;
(
  input wire logic        MCLK_IN,               // system clock
  input wire logic        RST_IN,                // async reset
  input wire logic        CORE_DSP_RELEASE_IN,   // core release request
  input wire logic        CFG_VALID_OUT,         // straps latched
  input wire bss_cfg_t    BOOT_CONFIG_OUT,       // raw straps
  input wire logic [3:0]  CORE_BOOT_MODE_OUT,    // core boot mode
  input wire logic [31:0] CORE_BRANCH_ADDR_OUT,  // branch address
  input wire logic        HOST_PORT_PIN_EN_OUT,  // host pin enable
  input wire logic        PCI_PIN_EN_OUT,        // pci pin enable
  input wire logic        DSP_ASYNC_ALLOWED_OUT, // dsp async access
  input wire logic        DSP_SELF_BOOT_OUT,     // effective self-boot
  input wire logic        DSP_RESET_N_OUT,       // dsp reset, low
  input wire logic        DSP_L1P_EN_OUT,        // program cache on
  input wire logic [31:0] DSP_BOOT_ADDR_OUT      // dsp start address
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);
  wire hp_sel = (BOOT_CONFIG_OUT.boot_mode_straps[3:1] == 3'h1);

  a_cfg_frozen: assert property ($past(CFG_VALID_OUT) |-> $stable(BOOT_CONFIG_OUT))
    else $error("latched config moved");
  a_host_force: assert property (CFG_VALID_OUT |->
    HOST_PORT_PIN_EN_OUT == (BOOT_CONFIG_OUT.boot_mode_straps == `BSS_HOST_CODE))
    else $error("host pin enable wrong");
  a_pci_force: assert property (CFG_VALID_OUT |->
    PCI_PIN_EN_OUT == (BOOT_CONFIG_OUT.boot_mode_straps == `BSS_PCI_CODE))
    else $error("pci pin enable wrong");
  a_self_override: assert property (CFG_VALID_OUT |->
    DSP_SELF_BOOT_OUT == (BOOT_CONFIG_OUT.dsp_self_boot_strap && !hp_sel))
    else $error("self-boot override wrong");
  a_async_block: assert property ((HOST_PORT_PIN_EN_OUT || PCI_PIN_EN_OUT) |->
    !DSP_ASYNC_ALLOWED_OUT) else $error("dsp kept async iface");
  a_nor_branch: assert property ($past(CFG_VALID_OUT) |->
    CORE_BRANCH_ADDR_OUT == ((CORE_BOOT_MODE_OUT == 4'h7) ? `BSS_NOR_ADDR : 32'h0))
    else $error("branch address wrong");
  a_self_release: assert property ($rose(DSP_SELF_BOOT_OUT) |-> ##[1:2] DSP_RESET_N_OUT)
    else $error("self-boot not released");
  a_self_start: assert property (DSP_RESET_N_OUT && DSP_SELF_BOOT_OUT |->
    DSP_L1P_EN_OUT && DSP_BOOT_ADDR_OUT == `BSS_DSP_BOOT_ADDR)
    else $error("self-boot start state wrong");
  a_core_gate: assert property ((!DSP_SELF_BOOT_OUT && !CORE_DSP_RELEASE_IN) [*4] |=>
    !$rose(DSP_RESET_N_OUT)) else $error("dsp freed without request");
  a_core_release: assert property ((CFG_VALID_OUT && CORE_DSP_RELEASE_IN) [*3] |->
    ##[1:2] DSP_RESET_N_OUT) else $error("core request ignored");

  c_self: cover property ($rose(DSP_SELF_BOOT_OUT));
  c_host: cover property ($rose(HOST_PORT_PIN_EN_OUT));
  c_core: cover property (!DSP_SELF_BOOT_OUT && $rose(DSP_RESET_N_OUT));
endmodule : bss_top_chk

bind bss_top bss_top_chk u_bss_top_chk (.MCLK_IN(MCLK_IN), .RST_IN(RST_IN),
  .CORE_DSP_RELEASE_IN(CORE_DSP_RELEASE_IN), .CFG_VALID_OUT(CFG_VALID_OUT),
  .BOOT_CONFIG_OUT(BOOT_CONFIG_OUT), .CORE_BOOT_MODE_OUT(CORE_BOOT_MODE_OUT),
  .CORE_BRANCH_ADDR_OUT(CORE_BRANCH_ADDR_OUT), .HOST_PORT_PIN_EN_OUT(HOST_PORT_PIN_EN_OUT),
  .PCI_PIN_EN_OUT(PCI_PIN_EN_OUT), .DSP_ASYNC_ALLOWED_OUT(DSP_ASYNC_ALLOWED_OUT),
  .DSP_SELF_BOOT_OUT(DSP_SELF_BOOT_OUT), .DSP_RESET_N_OUT(DSP_RESET_N_OUT),
  .DSP_L1P_EN_OUT(DSP_L1P_EN_OUT), .DSP_BOOT_ADDR_OUT(DSP_BOOT_ADDR_OUT));

// ===== verification/bss_core_model.sv
// general-purpose core model that frees the dsp after loading it
`timescale 1ns/1ps
module bss_core_model (
  input  wire logic       clk_in,  // system clock
  input  wire logic       go_in,   // core decides to free the dsp
  input  wire logic [3:0] lat_in,  // cycles spent placing dsp code
  output logic            rel_out  // release request, level
);
  logic [3:0] cnt;
  initial cnt = 4'h0;
  initial rel_out = 1'h0;
  // code is placed before the release, the dsp has no loader of its own
  always @(posedge clk_in) begin
    cnt <= go_in ? cnt + 4'h1 : 4'h0;
    rel_out <= go_in && (cnt >= lat_in);
  end
endmodule : bss_core_model

// ===== verification/tb_boot_strap_select.sv
// self-checking bench for the boot strap select block
`timescale 1ns/1ps
`include "bss_params.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_boot_strap_select;
  import bss_pkg::*;
  typedef struct packed {
    logic [3:0] mode;
    logic [1:0] bw;
    logic [5:0] fl; // pin, ok, xfer, host, pci, eff
  } bss_row_t;
  logic        clk, rst, pin, go, rel, valid, mval, xfer, host, pci, asyn, selfb, rst_n, l1p;
  logic [3:0]  mode, cmode, lat;
  logic [1:0]  bw, aw;
  logic [31:0] br, da;
  bss_cfg_t    cfg;
  bss_row_t    r;
  int          fails = 0, check_count = 0;
  bss_row_t    rows [10] = '{'{4'h0, 2'h1, 6'h18}, '{4'h1, 2'h2, 6'h39},
    '{4'h2, 2'h3, 6'h3c}, '{4'h3, 2'h0, 6'h3a}, '{4'h4, 2'h1, 6'h18}, '{4'h5, 2'h2, 6'h39},
    '{4'h6, 2'h3, 6'h18}, '{4'h7, 2'h2, 6'h31}, '{4'h8, 2'h1, 6'h21}, '{4'hf, 2'h3, 6'h00}};

  bss_top u_bss_top (.MCLK_IN(clk), .RST_IN(rst), .BOOT_MODE_STRAPS_IN(mode),
    .CS2_BUS_WIDTH_IN(bw), .DSP_SELF_BOOT_IN(pin), .CORE_DSP_RELEASE_IN(rel),
    .CFG_VALID_OUT(valid), .BOOT_CONFIG_OUT(cfg), .CORE_BOOT_MODE_OUT(cmode),
    .CORE_MODE_VALID_OUT(mval), .CORE_XFER_CODE_OUT(xfer), .CORE_BRANCH_ADDR_OUT(br),
    .ASYNC_ADDR_WIDTH_OUT(aw), .HOST_PORT_PIN_EN_OUT(host), .PCI_PIN_EN_OUT(pci),
    .DSP_ASYNC_ALLOWED_OUT(asyn), .DSP_SELF_BOOT_OUT(selfb), .DSP_RESET_N_OUT(rst_n),
    .DSP_L1P_EN_OUT(l1p), .DSP_BOOT_ADDR_OUT(da));
  bss_core_model u_bss_core_model (.clk_in(clk), .go_in(go), .lat_in(lat), .rel_out(rel));

  always #12.5 clk = ~clk;

  task automatic summarize();
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  // straps are set inside reset so they are stable across the sampling window
  task automatic apply(input logic [3:0] m, input logic [1:0] b, input logic p, input logic g);
    @(posedge clk);
    #2 rst = 1'h1;
    mode = m;
    bw = b;
    pin = p;
    go = g;
    lat = 4'h0;
    repeat (6) @(posedge clk);
    #2 rst = 1'h0;
    repeat (10) @(posedge clk);
    #2;
  endtask : apply

  initial begin
    #100000;
    fails++;
    summarize();
  end

  initial begin
    clk = 1'h0;
    rst = 1'h1;
    {mode, bw, pin, go, lat} = '0;
    for (int i = 0; i < 10; i++) begin
      r = rows[i];
      apply(r.mode, r.bw, r.fl[5], 1'h0);
      `CHK("valid", 1'h1, valid)
      `CHK("cfg", {r.mode, r.bw, r.fl[5], 1'h0}, cfg)
      `CHK("mode", r.mode, cmode)
      `CHK("mvalid", r.fl[4], mval)
      `CHK("xfer", r.fl[3], xfer)
      `CHK("branch", (r.mode == 4'h7) ? `BSS_NOR_ADDR : 32'h0, br)
      `CHK("width", (r.mode == 4'h7) ? r.bw : 2'h0, aw)
      `CHK("host", r.fl[2], host)
      `CHK("pci", r.fl[1], pci)
      `CHK("async", ~(r.fl[2] | r.fl[1]), asyn)
      `CHK("self", r.fl[0], selfb)
      `CHK("rst_n", r.fl[0], rst_n)
      `CHK("l1p", r.fl[0], l1p)
      `CHK("daddr", r.fl[0] ? `BSS_DSP_BOOT_ADDR : 32'h0, da)
      // late strap moves must not reach the latch; slow core release
      mode = ~r.mode;
      bw = ~r.bw;
      pin = ~r.fl[5];
      go = 1'h1;
      lat = i[3:0];
      repeat (20) @(posedge clk);
      #2 `CHK("hold", {r.mode, r.bw, r.fl[5], 1'h0}, cfg)
      `CHK("hself", r.fl[0], selfb)
      `CHK("rel", 1'h1, rst_n)
    end
    @(posedge clk);
    #2 rst = 1'h1;
    #1 `CHK("rstv", 1'h0, valid)
    `CHK("rstd", 1'h0, rst_n)
    @(posedge clk);
    #2 rst = 1'h0;
    // latch is still waiting for the synchroniser three edges after release
    repeat (3) @(posedge clk);
    #2 `CHK("wait", 1'h0, valid)
    apply(4'h2, 2'h1, 1'h1, 1'h1);
    `CHK("early", 1'h1, rst_n)
    `CHK("ovr", 1'h0, selfb)
    `CHK("true", 1'h1, cfg.dsp_self_boot_strap)
    summarize();
  end
endmodule : tb_boot_strap_select
